/* File: design/lrcp_core.sv */
`timescale 1ns/1ps
// Remote command port: APB register file, frame decoder and command execution.
module lrcp_core #(
    parameter int unsigned GAP_CYC = lrcp_pkg::GAP_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    rx_pin,
    output logic                         tx_pin,
    output lrcp_pkg::lrcp_link_cfg_t     link_cfg,
    output logic                         remote_mode,
    output logic                         dynamic_run,
    output logic                         dynamic_start,
    output logic                         limits_apply,
    output logic [31:0]                  level_a_current,
    output logic [31:0]                  level_b_current,
    output logic [31:0]                  level_a_duration,
    output logic [31:0]                  level_b_duration,
    output logic [31:0]                  rise_transition_time,
    output logic [31:0]                  fall_transition_time,
    output logic [1:0]                   dynamic_waveform_select,
    output logic [31:0]                  current_limit,
    output logic [31:0]                  voltage_limit,
    output logic [31:0]                  power_limit
);
    lrcp_pkg::lrcp_link_cfg_t cfg_q;
    lrcp_pkg::lrcp_char_t     rx_char;
    logic [31:0] preset_q [lrcp_pkg::NUM_PARAMS];
    logic [31:0] active_q [lrcp_pkg::NUM_PARAMS];
    logic [2:0]  pos_q;
    logic [7:0]  addr_q, fn_q, reg_q;
    logic [23:0] data_q;
    logic [19:0] gap_q;
    logic [31:0] frame_data;
    logic        frame_hit, tx_busy, remote_q, dyn_run_q, dyn_start_q, lim_apply_q;
    logic        apb_acc, apb_wr, cmd_valid, pre_valid;
    logic [7:0]  cmd_code;
    logic [3:0]  pre_idx;
    logic [31:0] pre_val;
    logic [11:0] act_off, pre_off;
    logic        pre_hit, act_hit;

    lrcp_uart u_uart (
        .clk      (clk),
        .rst_n    (rst_n),
        .cfg      (cfg_q),
        .rx_pin   (rx_pin),
        .tx_start (frame_hit),
        .tx_data  (cfg_q.station),
        .tx_pin   (tx_pin),
        .tx_busy  (tx_busy),
        .rx_char  (rx_char)
    );

    // A frame is complete and addressed to this station on its last good character.
    assign frame_data = {data_q, rx_char.data};
    assign frame_hit  = rx_char.valid && !rx_char.err && (pos_q == lrcp_pkg::FRAME_LAST)
                        && (addr_q == cfg_q.station);

    // Frame assembly; a bad character or a long silence restarts the frame.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_q  <= 3'h0;
            addr_q <= 8'h00;
            fn_q   <= 8'h00;
            reg_q  <= 8'h00;
            data_q <= 24'h00_0000;
            gap_q  <= 20'h0_0000;
        end else if (rx_char.valid) begin
            gap_q <= 20'h0_0000;
            if (rx_char.err || pos_q == lrcp_pkg::FRAME_LAST) begin
                pos_q <= 3'h0;
            end else begin
                pos_q <= pos_q + 3'h1;
            end
            unique case (pos_q)
                3'h0:    addr_q <= rx_char.data;
                3'h1:    fn_q   <= rx_char.data;
                3'h2:    reg_q  <= rx_char.data;
                default: data_q <= {data_q[15:0], rx_char.data};
            endcase
        end else if (pos_q != 3'h0) begin
            if (gap_q == 20'(GAP_CYC - 1)) begin
                pos_q <= 3'h0;
                gap_q <= 20'h0_0000;
            end else begin
                gap_q <= gap_q + 20'h0_0001;
            end
        end
    end

    // APB: the access phase is stalled only in the cycle a frame executes.
    assign apb_acc = psel && penable && pready;
    assign apb_wr  = apb_acc && pwrite;
    assign pready  = !frame_hit;
    assign pre_off = paddr - lrcp_pkg::OFF_PRESET_BASE;
    assign act_off = paddr - lrcp_pkg::OFF_ACTIVE_BASE;
    assign pre_hit = (paddr >= lrcp_pkg::OFF_PRESET_BASE) && (paddr[1:0] == 2'b00)
                     && (pre_off[11:2] < 10'(lrcp_pkg::NUM_PARAMS));
    assign act_hit = (paddr >= lrcp_pkg::OFF_ACTIVE_BASE) && (paddr[1:0] == 2'b00)
                     && (act_off[11:2] < 10'(lrcp_pkg::NUM_PARAMS));

    // Merge the two sources of presets and commands; only one can act per cycle.
    always_comb begin
        cmd_valid = 1'b0;
        cmd_code  = 8'h00;
        pre_valid = 1'b0;
        pre_idx   = 4'h0;
        pre_val   = 32'h0000_0000;
        if (frame_hit && fn_q == lrcp_pkg::FN_PRESET) begin
            if (reg_q == lrcp_pkg::REG_CMD) begin
                cmd_valid = 1'b1;
                cmd_code  = frame_data[7:0];
            end else if (reg_q < 8'(lrcp_pkg::NUM_PARAMS)) begin
                pre_valid = 1'b1;
                pre_idx   = reg_q[3:0];
                pre_val   = frame_data;
            end
        end else if (apb_wr && paddr == lrcp_pkg::OFF_COMMAND) begin
            cmd_valid = 1'b1;
            cmd_code  = pwdata[7:0];
        end else if (apb_wr && pre_hit) begin
            pre_valid = 1'b1;
            pre_idx   = pre_off[5:2];
            pre_val   = pwdata;
        end
        if (pre_idx == lrcp_pkg::IDX_WAVE_SEL && pre_val > lrcp_pkg::WAVE_SEL_MAX) begin
            pre_valid = 1'b0;
        end
    end

    // Presets are only stored here; nothing downstream sees them yet.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < lrcp_pkg::NUM_PARAMS; i++) begin
                preset_q[i] <= 32'h0000_0000;
            end
        end else if (pre_valid) begin
            preset_q[pre_idx] <= pre_val;
        end
    end

    // Command codes copy their group of presets to the active set in one cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < lrcp_pkg::NUM_PARAMS; i++) begin
                active_q[i] <= 32'h0000_0000;
            end
            dyn_run_q   <= 1'b0;
            dyn_start_q <= 1'b0;
            lim_apply_q <= 1'b0;
        end else begin
            dyn_start_q <= 1'b0;
            lim_apply_q <= 1'b0;
            if (cmd_valid) begin
                if (cmd_code == lrcp_pkg::CMD_DYNAMIC) begin
                    for (int i = 0; i <= int'(lrcp_pkg::IDX_WAVE_SEL); i++) begin
                        active_q[i] <= preset_q[i];
                    end
                    dyn_run_q   <= 1'b1;
                    dyn_start_q <= 1'b1;
                end else if (cmd_code == lrcp_pkg::CMD_SYSTEM) begin
                    for (int i = int'(lrcp_pkg::IDX_CUR_LIMIT);
                         i <= int'(lrcp_pkg::IDX_PWR_LIMIT); i++) begin
                        active_q[i] <= preset_q[i];
                    end
                    lim_apply_q <= 1'b1;
                end else begin
                    dyn_run_q <= 1'b0;  // Any other mode ends dynamic testing.
                end
            end
        end
    end

    // Remote flag: only the two documented coil values change it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_q <= 1'b0;
        end else if (frame_hit && fn_q == lrcp_pkg::FN_COIL && reg_q == lrcp_pkg::COIL_REMOTE) begin
            if (frame_data[15:0] == lrcp_pkg::COIL_ON) begin
                remote_q <= 1'b1;
            end else if (frame_data[15:0] == lrcp_pkg::COIL_OFF) begin
                remote_q <= 1'b0;
            end
        end
    end

    // Link setup from the local bus or from a frame; the reply leaves at the old rate.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q.baud    <= lrcp_pkg::BAUD_SEL_9600;
            cfg_q.parity  <= lrcp_pkg::PAR_NONE;
            cfg_q.station <= lrcp_pkg::STATION_RST;
        end else if (frame_hit && fn_q == lrcp_pkg::FN_LINK_CFG && !tx_busy) begin
            cfg_q.baud    <= frame_data[lrcp_pkg::CFG_BAUD_LSB +: 2];
            cfg_q.parity  <= frame_data[lrcp_pkg::CFG_PAR_LSB +: 2];
            cfg_q.station <= frame_data[lrcp_pkg::CFG_STATION_LSB +: 8];
        end else if (apb_wr && paddr == lrcp_pkg::OFF_LINK_CFG) begin
            cfg_q.baud    <= pwdata[lrcp_pkg::CFG_BAUD_LSB +: 2];
            cfg_q.parity  <= pwdata[lrcp_pkg::CFG_PAR_LSB +: 2];
            cfg_q.station <= pwdata[lrcp_pkg::CFG_STATION_LSB +: 8];
        end
    end

    // Read data and the error flag are latched in the setup cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= !(paddr == lrcp_pkg::OFF_LINK_CFG || paddr == lrcp_pkg::OFF_STATUS
                         || paddr == lrcp_pkg::OFF_COMMAND || pre_hit || act_hit);
            if (paddr == lrcp_pkg::OFF_LINK_CFG) begin
                prdata <= {16'h0000, cfg_q.station, 4'h0, cfg_q.parity, cfg_q.baud};
            end else if (paddr == lrcp_pkg::OFF_STATUS) begin
                prdata <= {29'h0000_0000, tx_busy, remote_q, dyn_run_q};
            end else if (pre_hit) begin
                prdata <= preset_q[pre_off[5:2]];
            end else if (act_hit) begin
                prdata <= active_q[act_off[5:2]];
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    assign link_cfg                = cfg_q;
    assign remote_mode             = remote_q;
    assign dynamic_run             = dyn_run_q;
    assign dynamic_start           = dyn_start_q;
    assign limits_apply            = lim_apply_q;
    assign level_a_current         = active_q[0];
    assign level_b_current         = active_q[1];
    assign level_a_duration        = active_q[2];
    assign level_b_duration        = active_q[3];
    assign rise_transition_time    = active_q[4];
    assign fall_transition_time    = active_q[5];
    assign dynamic_waveform_select = active_q[6][1:0];
    assign current_limit           = active_q[7];
    assign voltage_limit           = active_q[8];
    assign power_limit             = active_q[9];
endmodule

/* File: design/lrcp_uart.sv */
`timescale 1ns/1ps
// Character transmitter and receiver: start, 8 data, optional parity, 1 stop.
module lrcp_uart (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  lrcp_pkg::lrcp_link_cfg_t     cfg,
    input  wire logic                    rx_pin,
    input  wire logic                    tx_start,
    input  wire logic [7:0]              tx_data,
    output logic                         tx_pin,
    output logic                         tx_busy,
    output lrcp_pkg::lrcp_char_t         rx_char
);
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} lrcp_rx_t;

    lrcp_rx_t    rx_state_q;
    logic        rx_meta_q, rx_sync_q;
    logic [15:0] bit_len, rx_cnt_q, tx_cnt_q, tx_len_q;
    logic [2:0]  rx_bit_q;
    logic [7:0]  rx_shift_q;
    logic        rx_par_bad_q;
    logic        par_on, par_odd;
    logic [10:0] tx_shift_q;
    logic [3:0]  tx_left_q;

    // Bit period for the selected rate.
    always_comb begin
        unique case (cfg.baud)
            lrcp_pkg::BAUD_SEL_4800:  bit_len = lrcp_pkg::BIT_4800;
            lrcp_pkg::BAUD_SEL_9600:  bit_len = lrcp_pkg::BIT_9600;
            lrcp_pkg::BAUD_SEL_19200: bit_len = lrcp_pkg::BIT_19200;
            lrcp_pkg::BAUD_SEL_38400: bit_len = lrcp_pkg::BIT_38400;
        endcase
    end

    assign par_on  = (cfg.parity == lrcp_pkg::PAR_EVEN) || (cfg.parity == lrcp_pkg::PAR_ODD);
    assign par_odd = (cfg.parity == lrcp_pkg::PAR_ODD);

    // Two-stage synchroniser on the receive pin.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_pin;
            rx_sync_q <= rx_meta_q;
        end
    end

    // Receiver: samples each bit at its middle and checks parity and stop.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_q   <= RX_IDLE;
            rx_cnt_q     <= 16'h0000;
            rx_bit_q     <= 3'h0;
            rx_shift_q   <= 8'h00;
            rx_par_bad_q <= 1'b0;
            rx_char      <= '0;
        end else begin
            rx_char.valid <= 1'b0;
            if (rx_state_q != RX_IDLE && rx_cnt_q != 16'h0000) begin
                rx_cnt_q <= rx_cnt_q - 16'h0001;
            end
            unique case (rx_state_q)
                RX_IDLE: if (!rx_sync_q) begin
                    rx_state_q   <= RX_START;
                    rx_cnt_q     <= {1'b0, bit_len[15:1]};
                    rx_par_bad_q <= 1'b0;
                end
                RX_START: if (rx_cnt_q == 16'h0000) begin
                    rx_state_q <= rx_sync_q ? RX_IDLE : RX_DATA;
                    rx_cnt_q   <= bit_len;
                    rx_bit_q   <= 3'h0;
                end
                RX_DATA: if (rx_cnt_q == 16'h0000) begin
                    rx_shift_q <= {rx_sync_q, rx_shift_q[7:1]};
                    rx_bit_q   <= rx_bit_q + 3'h1;
                    rx_cnt_q   <= bit_len;
                    if (rx_bit_q == 3'h7) begin
                        rx_state_q <= par_on ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: if (rx_cnt_q == 16'h0000) begin
                    rx_par_bad_q <= (^rx_shift_q ^ rx_sync_q) != par_odd;
                    rx_cnt_q     <= bit_len;
                    rx_state_q   <= RX_STOP;
                end
                RX_STOP: if (rx_cnt_q == 16'h0000) begin
                    rx_char.valid <= 1'b1;
                    rx_char.data  <= rx_shift_q;
                    rx_char.err   <= rx_par_bad_q || !rx_sync_q;
                    rx_state_q    <= RX_IDLE;
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // Transmitter: loads the whole character and shifts it out lsb first.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_shift_q <= 11'h7ff;
            tx_left_q  <= 4'h0;
            tx_cnt_q   <= 16'h0000;
            tx_len_q   <= 16'h0000;
        end else if (tx_left_q == 4'h0) begin
            if (tx_start) begin
                tx_shift_q <= par_on ? {1'b1, ^tx_data ^ par_odd, tx_data, 1'b0}
                                     : {2'b11, tx_data, 1'b0};
                tx_left_q  <= par_on ? 4'hb : 4'ha;
                tx_cnt_q   <= bit_len;
                tx_len_q   <= bit_len;  // A rate change mid-character keeps the old rate.
            end
        end else if (tx_cnt_q == 16'h0001) begin
            tx_shift_q <= {1'b1, tx_shift_q[10:1]};
            tx_left_q  <= tx_left_q - 4'h1;
            tx_cnt_q   <= tx_len_q;
        end else begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
        end
    end

    assign tx_pin  = (tx_left_q == 4'h0) ? 1'b1 : tx_shift_q[0];
    assign tx_busy = (tx_left_q != 4'h0);
endmodule

/* File: dv/lrcp_core_checker.sv */
`timescale 1ns/1ps
// Checks pulse, hold and range relations of the command port outputs.
module lrcp_core_checker #(
    parameter int unsigned GAP_CYC = 1
) (
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic                     pready,
    input wire lrcp_pkg::lrcp_link_cfg_t link_cfg,
    input wire logic                     remote_mode,
    input wire logic                     dynamic_run,
    input wire logic                     dynamic_start,
    input wire logic                     limits_apply,
    input wire logic [31:0]              level_a_current,
    input wire logic [1:0]               dynamic_waveform_select,
    input wire logic [31:0]              current_limit
);
    // Completed APB writes to the command and link configuration words.
    wire logic wr_done = psel && penable && pready && pwrite;
    wire logic cmd_wr  = wr_done && (paddr == lrcp_pkg::OFF_COMMAND);
    wire logic cfg_wr  = wr_done && (paddr == lrcp_pkg::OFF_LINK_CFG);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_dyn_start: assert property (cmd_wr && pwdata[7:0] == lrcp_pkg::CMD_DYNAMIC |=> dynamic_start && dynamic_run)
        else $error("dynamic start missing after command");
    chk_start_pulse: assert property (dynamic_start |=> !dynamic_start)
        else $error("dynamic start longer than one cycle");
    chk_limits_apply: assert property (cmd_wr && pwdata[7:0] == lrcp_pkg::CMD_SYSTEM |=> limits_apply)
        else $error("limits not applied after command");
    chk_active_hold: assert property ($changed(level_a_current) |-> dynamic_start)
        else $error("active level changed without command");
    chk_limit_hold: assert property ($changed(current_limit) |-> limits_apply)
        else $error("limit changed without command");
    chk_wave_range: assert property (dynamic_waveform_select != 2'h3)
        else $error("waveform select out of range");
    chk_remote_src: assert property ($changed(remote_mode) |-> $past(pready) == 1'b0)
        else $error("remote flag changed without frame");
    chk_cfg_src: assert property ($changed(link_cfg) |-> $past(pready) == 1'b0 || $past(cfg_wr))
        else $error("link configuration changed without request");
    // Main scenarios.
    cover property (dynamic_start);
    cover property (limits_apply);
    cover property ($rose(remote_mode));
endmodule

/* File: dv/lrcp_host_model.sv */
`timescale 1ns/1ps
// Host end of the serial link: sends even parity characters and takes replies.
module lrcp_host_model #(
    parameter int unsigned BIT_CYC = 2604
) (
    input  wire logic       clk,
    input  wire logic       tx_pin,
    output logic            line,
    output logic [7:0]      rep_data,
    output logic            rep_valid
);
    initial line = 1'b1;
    initial rep_valid = 1'b0;
    // Holds the line for one bit time.
    task automatic hold_bit(input logic b);
        line <= b;
        repeat (BIT_CYC) @(posedge clk);
    endtask
    // Start bit, eight data bits low first, parity, one stop bit.
    task automatic send_byte(input logic [7:0] d);
        hold_bit(1'b0);
        for (int i = 0; i < 8; i++) hold_bit(d[i]);
        hold_bit(^d);
        hold_bit(1'b1);
    endtask
    // Samples each reply mid-bit; only a good parity and stop yield a valid.
    initial begin
        logic [9:0] r;
        forever begin
            @(negedge tx_pin);
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int i = 0; i < 10; i++) begin
                repeat (BIT_CYC) @(posedge clk);
                r[i] = tx_pin;
            end
            rep_data <= r[7:0];
            rep_valid <= (r[8] == ^r[7:0]) && r[9];
            @(posedge clk);
            rep_valid <= 1'b0;
            repeat (BIT_CYC / 2) @(posedge clk);
        end
    end
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
// Drives the command port over APB and the serial link and checks its answers.
module tb;
    localparam int unsigned GAP = 40000;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        host_line, tx_pin, rep_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  rep_data;
    logic [32:0] rd_q[$];
    logic [7:0]  rep_q[$];
    logic [31:0] v[10];
    logic [55:0] fr;
    int          error_cnt, cmp_count, seed;

    lrcp_core #(.GAP_CYC(GAP)) dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rx_pin(host_line), .tx_pin, .link_cfg(), .remote_mode(),
        .dynamic_run(), .dynamic_start(), .limits_apply(), .level_a_current(),
        .level_b_current(), .level_a_duration(), .level_b_duration(),
        .rise_transition_time(), .fall_transition_time(), .dynamic_waveform_select(),
        .current_limit(), .voltage_limit(), .power_limit());
    lrcp_host_model #(.BIT_CYC(lrcp_pkg::BIT_38400)) host_u (.clk, .tx_pin,
        .line(host_line), .rep_data, .rep_valid);

    // Free running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // One APB transfer, held until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Notes the expected error flag and data, then reads.
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_rep(input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic close_out;
        error_cnt += rd_q.size() + rep_q.size();
        if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Compares each result with the oldest note when it appears.
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && rd_q.size() > 0)
            cmp_rd(rd_q.pop_front(), {pslverr, prdata});
        if (rep_valid === 1'b1 && rep_q.size() > 0) cmp_rep(rep_q.pop_front(), rep_data);
    end
    // Cuts a hang short well after the serial frame should be done.
    initial begin
        #3_500_000;
        error_cnt++;
        close_out;
    end
    // Main sequence.
    initial begin
        seed = 77990;
        error_cnt = 0;
        cmp_count = 0;
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(lrcp_pkg::OFF_LINK_CFG, 33'h0_0000_0101);
        for (int g = 0; g < 2; g++) begin
            for (int i = g * 7; i < (g ? 10 : 7); i++) begin
                v[i] = (i == 6) ? lrcp_pkg::WAVE_SEL_MAX : $random(seed);
                wr(lrcp_pkg::OFF_PRESET_BASE + 12'(4 * i), v[i]);
            end
            if (g == 0) wr(lrcp_pkg::OFF_PRESET_BASE + 12'h018, 32'h0000_0003);
            rd(lrcp_pkg::OFF_ACTIVE_BASE + 12'(28 * g), 33'h0_0000_0000);
            wr(lrcp_pkg::OFF_COMMAND, {24'h00_0000, g ? 8'h29 : 8'h19});
            if (g == 0) rd(lrcp_pkg::OFF_STATUS, 33'h0_0000_0001);
            for (int i = g * 7; i < (g ? 10 : 7); i++)
                rd(lrcp_pkg::OFF_ACTIVE_BASE + 12'(4 * i), {1'b0, v[i]});
        end
        wr(lrcp_pkg::OFF_COMMAND, 32'h0000_0000);
        rd(12'h100, 33'h1_0000_0000);
        wr(lrcp_pkg::OFF_LINK_CFG, 32'h0000_0507);
        rd(lrcp_pkg::OFF_LINK_CFG, 33'h0_0000_0507);
        rep_q.push_back(8'h05);
        fr = {8'h05, lrcp_pkg::FN_COIL, lrcp_pkg::COIL_REMOTE, 16'h0000, lrcp_pkg::COIL_ON};
        for (int k = 0; k < 7; k++) host_u.send_byte(fr[55 - 8 * k -: 8]);
        for (int k = 0; k < 60000 && rep_q.size() != 0; k++) @(posedge clk);
        repeat (lrcp_pkg::BIT_38400) @(posedge clk); // Let the reply's stop bit end.
        rd(lrcp_pkg::OFF_STATUS, 33'h0_0000_0002);
        close_out;
    end
endmodule
bind lrcp_core lrcp_core_checker #(.GAP_CYC(GAP_CYC)) chk_u (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .link_cfg, .remote_mode, .dynamic_run, .dynamic_start,
    .limits_apply, .level_a_current, .dynamic_waveform_select, .current_limit);

/* File: shared/lrcp_pkg.sv */
// Behaviour
// - Dynamic testing starts only when command code 25 is written to the command register.
// - Dynamic testing starts with the latest preset levels, durations and transition times.
// - The waveform select preset takes only the values 0 to 2 and is optional.
// - Command code 41 adopts the preset current, voltage and power limits as the new maximums.
// - A single-coil write of 0xFF00 sets the remote flag and 0x0000 clears it.
// - The serial rate is selectable among 4800, 9600, 19200 and 38400 baud, 9600 by default.
// - Parity is none, even or odd, and characters failing the check are rejected.
// - Requests with a foreign station address or a wrong rate are ignored.
// - Rate and station address can be changed locally over the bus and remotely by frame.
// - Forcing the remote control coil to one enters remote control, zero leaves it.
package lrcp_pkg;

    // Clock and serial timing.
    localparam int unsigned CLK_HZ     = 100_000_000;
    localparam int unsigned BAUD_4800  = 4800;
    localparam int unsigned BAUD_9600  = 9600;
    localparam int unsigned BAUD_19200 = 19200;
    localparam int unsigned BAUD_38400 = 38400;
    localparam logic [15:0] BIT_4800   = 16'(CLK_HZ / BAUD_4800);
    localparam logic [15:0] BIT_9600   = 16'(CLK_HZ / BAUD_9600);
    localparam logic [15:0] BIT_19200  = 16'(CLK_HZ / BAUD_19200);
    localparam logic [15:0] BIT_38400  = 16'(CLK_HZ / BAUD_38400);
    localparam int unsigned GAP_US     = 4000;
    localparam int unsigned GAP_CYC    = GAP_US * (CLK_HZ / 1_000_000);

    // Link configuration encodings and reset values.
    localparam logic [1:0] BAUD_SEL_4800  = 2'h0;
    localparam logic [1:0] BAUD_SEL_9600  = 2'h1;
    localparam logic [1:0] BAUD_SEL_19200 = 2'h2;
    localparam logic [1:0] BAUD_SEL_38400 = 2'h3;
    localparam logic [1:0] PAR_NONE       = 2'h0;
    localparam logic [1:0] PAR_EVEN       = 2'h1;
    localparam logic [1:0] PAR_ODD        = 2'h2;
    localparam logic [7:0] STATION_RST    = 8'h01;

    // Register map, byte addresses.
    localparam logic [11:0] OFF_LINK_CFG    = 12'h000;
    localparam logic [11:0] OFF_STATUS      = 12'h004;
    localparam logic [11:0] OFF_COMMAND     = 12'h008;
    localparam logic [11:0] OFF_PRESET_BASE = 12'h040;
    localparam logic [11:0] OFF_ACTIVE_BASE = 12'h080;

    // Link configuration field positions.
    localparam int CFG_BAUD_LSB    = 0;
    localparam int CFG_PAR_LSB     = 2;
    localparam int CFG_STATION_LSB = 8;

    // Parameter table indices.
    localparam int NUM_PARAMS             = 10;
    localparam logic [3:0] IDX_LEVEL_A_CUR = 4'h0;
    localparam logic [3:0] IDX_WAVE_SEL    = 4'h6;
    localparam logic [3:0] IDX_CUR_LIMIT   = 4'h7;
    localparam logic [3:0] IDX_PWR_LIMIT   = 4'h9;
    localparam logic [31:0] WAVE_SEL_MAX   = 32'h0000_0002;

    // Frame layout: station, function, register, four data bytes.
    localparam logic [2:0] FRAME_LAST  = 3'h6;
    localparam logic [7:0] FN_PRESET   = 8'h10;
    localparam logic [7:0] FN_COIL     = 8'h05;
    localparam logic [7:0] FN_LINK_CFG = 8'h06;
    localparam logic [7:0] REG_CMD     = 8'h20;
    localparam logic [7:0] COIL_REMOTE = 8'h00;
    localparam logic [15:0] COIL_ON    = 16'hFF00;
    localparam logic [15:0] COIL_OFF   = 16'h0000;
    localparam logic [7:0] CMD_DYNAMIC = 8'h19;
    localparam logic [7:0] CMD_SYSTEM  = 8'h29;

    typedef struct packed {
        logic [7:0] station;
        logic [1:0] parity;
        logic [1:0] baud;
    } lrcp_link_cfg_t;

    typedef struct packed {
        logic       valid;
        logic       err;
        logic [7:0] data;
    } lrcp_char_t;

endpackage
